// *** stc_card_model.sv ***
// Purpose: Behavioural storage card writer facing the trigger controller.
// Assumes: A word is taken on card_valid and card_ready at a clk_sys rising edge.
// Notes: Slow mode stalls every other cycle so the sample FIFO backs up.
`timescale 1ns/1ns
module stc_card_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Card stream
	input wire logic card_valid,
	output logic card_ready,
	input wire logic [63:0] card_data,
	input wire logic card_close,
	output logic card_closed,
	// Bench control and status
	input wire logic slow,
	output int words,
	output logic [63:0] sum,
	output logic done
);
	logic [1:0] wait_q;
	logic toggle_q;
	// The word count and a running sum of card_data are kept; the contents are not compared here.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wait_q <= 2'h0;
			toggle_q <= 1'b0;
			card_ready <= 1'b0;
			card_closed <= 1'b0;
			words <= 0;
			sum <= '0;
			done <= 1'b0;
		end else begin
			toggle_q <= ~toggle_q;
			card_ready <= !slow || toggle_q;
			if (card_valid && card_ready) begin
				words <= words + 1;
				sum <= sum + card_data;
				done <= 1'b0;
			end
			card_closed <= (wait_q == 2'h1);
			if (card_close) begin
				wait_q <= 2'h3;
				done <= 1'b0;
			end else if (wait_q != 2'h0) begin
				wait_q <= wait_q - 2'h1;
			end
			if (wait_q == 2'h1) begin
				done <= 1'b1;
			end
		end
	end
endmodule

// *** stc_cond.sv ***
// Purpose: One trigger condition: field pick, mask and compare.
// Assumes: Record bytes are little-endian; size is 1 to 4 bytes.
// Notes: Purely combinational; the caller samples fire only on a taken record.
`timescale 1ns/1ns
module stc_cond #(
	parameter int REC_W = 64
) (
	// Settings
	input wire logic [1:0] sel,
	input wire logic [stc_pkg::OFF_W-1:0] offset,
	input wire logic [stc_pkg::SIZE_W-1:0] size,
	input wire logic [stc_pkg::DATA_W-1:0] mask,
	input wire logic [stc_pkg::DATA_W-1:0] value,
	// Sample record
	input wire logic [REC_W-1:0] rec,
	// Result
	output logic enabled,
	output logic fire
);
	import stc_pkg::*;

	// Bytes beyond the chosen size read as zero so narrow variables compare cleanly.
	function automatic logic [DATA_W-1:0] pick(input logic [REC_W-1:0] r, input logic [OFF_W-1:0] o,
		input logic [SIZE_W-1:0] s);
		logic [REC_W-1:0] sh;
		logic [DATA_W-1:0] f;
		sh = r >> {o, 3'h0};
		for (int i = 0; i < DATA_W / BYTE_W; i++) begin
			f[i*BYTE_W +: BYTE_W] = (i < int'(s)) ? sh[i*BYTE_W +: BYTE_W] : 8'h00;
		end
		return f;
	endfunction

	logic equal;

	always_comb begin
		equal = ((pick(rec, offset, size) & mask) == value);
		enabled = (sel == SEL_MATCH) || (sel == SEL_FIRE_ON_MISMATCH);
		fire = ((sel == SEL_MATCH) && equal) || ((sel == SEL_FIRE_ON_MISMATCH) && !equal);
	end
endmodule

// *** stc_fifo.sv ***
// Purpose: Sample FIFO between capture and the card writer.
// Assumes: One clock; synchronous active-low reset.
// Notes: Read data come from a register stage, so idle covers that stage too.
`timescale 1ns/1ns
module stc_fifo #(
	parameter int W = 64,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	// Status
	output logic idle
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic ov_q;
	logic [W-1:0] od_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = (cnt_q != '0) && (!ov_q || out_ready);
	assign out_valid = ov_q;
	assign out_data = od_q;
	assign idle = (cnt_q == '0) && !ov_q;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
			rd_q <= pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ov_q <= 1'b0;
			od_q <= '0;
		end else if (pop) begin
			ov_q <= 1'b1;
			od_q <= mem[rd_q];
		end else if (out_ready) begin
			ov_q <= 1'b0;
		end
	end
endmodule

// *** stc_pkg.sv ***
// Purpose: Shared constants for the sampling trigger controller.
// Assumes: 25 MHz clk_sys, synchronous active-low reset.
// Notes: Condition selector and status codes are the encodings seen at the ports.
//
// Summary of operation
// - Start and end each have a selector: disabled, fire on match, fire on mismatch.
// - The variable value is ANDed with the mask before comparing.
// - Masked value vs judgment value; match fires on equal, mismatch on unequal.
// - Start and end keep their own variable, offset, size, mask and value.
// - Start command with enabled start condition enters trigger wait until it fires.
// - Start condition firing, or disabled start condition, enters sampling at once.
// - A start command is ignored unless the status is stop.
// - Start with the storage card absent is refused and flags a storage error.
// - With power-on start enabled, sampling begins automatically after power-on.
// - Capture ends when the end condition fires or the buffer is full.
// - A manual end command during sampling ends capture.
// - After capture ends the collected samples are written to the card.
// - Status returns to stop only after the card write has fully completed.
package stc_pkg;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int OFF_W = 3;
	localparam int SIZE_W = 3;
	// Condition selector codes.
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_MATCH = 2'h1;
	localparam logic [1:0] SEL_FIRE_ON_MISMATCH = 2'h2;
	// Status codes.
	localparam logic [1:0] STAT_STOP = 2'h0;
	localparam logic [1:0] STAT_WAIT = 2'h1;
	localparam logic [1:0] STAT_SAMPLING = 2'h2;
	localparam logic [1:0] STAT_WRITING = 2'h3;
	// Cycles for the card-present synchroniser to settle after reset.
	localparam logic [1:0] SYNC_SETTLE = 2'h2;
	typedef enum logic [2:0] {ST_STOP, ST_WAIT, ST_SAMP, ST_FLUSH, ST_CLOSE} stc_state_t;
endpackage

// *** stc_trigger_ctrl.sv ***
// Purpose: Arms, starts and stops sample capture and hands samples to the card writer.
// Assumes: Commands and settings come from logic on clk_sys; card_present is a pin.
// Notes: Each accepted samp_valid beat is one sampling cycle.
`timescale 1ns/1ns
module stc_trigger_ctrl #(
	parameter int REC_W = 64,
	parameter int CNT_W = 16,
	parameter logic [15:0] BUF_SAMPLES = 16'h0400,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Operator commands, one-cycle pulses
	input wire logic start_cmd,
	input wire logic end_cmd,
	input wire logic err_clr,
	// Start condition settings
	input wire logic power_on_start,
	input wire logic [1:0] start_sel,
	input wire logic [stc_pkg::OFF_W-1:0] start_offset,
	input wire logic [stc_pkg::SIZE_W-1:0] start_size,
	input wire logic [stc_pkg::DATA_W-1:0] start_mask,
	input wire logic [stc_pkg::DATA_W-1:0] start_value,
	// End condition settings
	input wire logic [1:0] end_sel,
	input wire logic [stc_pkg::OFF_W-1:0] end_offset,
	input wire logic [stc_pkg::SIZE_W-1:0] end_size,
	input wire logic [stc_pkg::DATA_W-1:0] end_mask,
	input wire logic [stc_pkg::DATA_W-1:0] end_value,
	// Variable samples
	input wire logic samp_valid,
	output logic samp_ready,
	input wire logic [REC_W-1:0] samp_rec,
	// Storage card
	input wire logic card_present,
	output logic card_valid,
	input wire logic card_ready,
	output logic [REC_W-1:0] card_data,
	output logic card_close,
	input wire logic card_closed,
	// Status
	output logic [1:0] status,
	output logic storage_err,
	output logic [CNT_W-1:0] samp_count
);
	import stc_pkg::*;

	stc_state_t state_q;
	stc_state_t state_d;
	logic card_s1_q;
	logic card_s2_q;
	logic [1:0] settle_q;
	logic por_pend_q;
	logic err_q;
	logic close_q;
	logic [1:0] status_q;
	logic [CNT_W-1:0] count_q;
	logic start_en;
	logic start_fire;
	logic end_en;
	logic end_fire;
	logic fifo_in_ready;
	logic fifo_idle;
	logic por_go;
	logic go;
	logic accept_start;
	logic refuse_start;
	logic take;
	logic push;
	logic buf_full;

	function automatic logic [1:0] stat_of(input stc_state_t s);
		case (s)
			ST_STOP: stat_of = STAT_STOP;
			ST_WAIT: stat_of = STAT_WAIT;
			ST_SAMP: stat_of = STAT_SAMPLING;
			default: stat_of = STAT_WRITING;
		endcase
	endfunction

	stc_cond #(.REC_W(REC_W)) u_start_cond (
		.sel(start_sel),
		.offset(start_offset),
		.size(start_size),
		.mask(start_mask),
		.value(start_value),
		.rec(samp_rec),
		.enabled(start_en),
		.fire(start_fire)
	);

	stc_cond #(.REC_W(REC_W)) u_end_cond (
		.sel(end_sel),
		.offset(end_offset),
		.size(end_size),
		.mask(end_mask),
		.value(end_value),
		.rec(samp_rec),
		.enabled(end_en),
		.fire(end_fire)
	);

	stc_fifo #(.W(REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(samp_rec),
		.out_valid(card_valid),
		.out_ready(card_ready),
		.out_data(card_data),
		.idle(fifo_idle)
	);

	// The card-present pin is asynchronous to clk_sys.
	// Card removal after the start check is not observed; a pulled card only shows as a stalled writer.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			card_s1_q <= 1'b0;
			card_s2_q <= 1'b0;
		end else begin
			card_s1_q <= card_present;
			card_s2_q <= card_s1_q;
		end
	end

	// Power-on start waits for the synchroniser to settle, else it would see no card.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			settle_q <= 2'h0;
			por_pend_q <= 1'b1;
		end else begin
			settle_q <= (settle_q == SYNC_SETTLE) ? settle_q : settle_q + 2'h1;
			por_pend_q <= por_pend_q && (settle_q != SYNC_SETTLE);
		end
	end

	assign por_go = por_pend_q && (settle_q == SYNC_SETTLE) && power_on_start;
	assign go = start_cmd || por_go;
	assign accept_start = go && (state_q == ST_STOP) && card_s2_q;
	assign refuse_start = go && (state_q == ST_STOP) && !card_s2_q;

	// Records offered in trigger wait are consumed even when they do not fire, so the source never stalls.
	// one evaluation per taken sample
	assign samp_ready = ((state_q == ST_WAIT) || (state_q == ST_SAMP)) && fifo_in_ready;
	assign take = samp_valid && samp_ready;
	// the firing sample is the first one kept
	assign push = take && ((state_q == ST_SAMP) || start_fire);
	assign buf_full = push && (count_q == CNT_W'(BUF_SAMPLES - 16'h1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_STOP: begin
				if (accept_start) begin
					state_d = start_en ? ST_WAIT : ST_SAMP;
				end
			end
			ST_WAIT: begin
				if (end_cmd) begin
					state_d = ST_STOP;
				end else if (take && start_fire) begin
					state_d = ST_SAMP;
				end
			end
			ST_SAMP: begin
				if (end_cmd || buf_full || (take && end_en && end_fire)) begin
					state_d = ST_FLUSH;
				end
			end
			ST_FLUSH: begin
				if (fifo_idle) begin
					state_d = ST_CLOSE;
				end
			end
			ST_CLOSE: begin
				// stop only once card is done
				if (card_closed) begin
					state_d = ST_STOP;
				end
			end
			default: state_d = ST_STOP;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_q <= ST_STOP;
			status_q <= STAT_STOP;
		end else begin
			state_q <= state_d;
			status_q <= stat_of(state_d);
		end
	end

	// one close pulse after the last sample leaves
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			close_q <= 1'b0;
		end else begin
			close_q <= (state_q == ST_FLUSH) && fifo_idle;
		end
	end

	// sticky error, set wins over clear
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			err_q <= 1'b0;
		end else begin
			err_q <= refuse_start || (err_q && !err_clr);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			count_q <= '0;
		end else if (accept_start) begin
			count_q <= '0;
		end else if (push) begin
			count_q <= count_q + CNT_W'(1);
		end
	end

	assign status = status_q;
	assign storage_err = err_q;
	assign samp_count = count_q;
	assign card_close = close_q;

	a_refuse_err: assert property (@(posedge clk_sys) disable iff (!reset_n)
		refuse_start |=> storage_err && (state_q == ST_STOP))
		else $error("start without card did not flag storage error");

	a_busy_ignore: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(start_cmd && (state_q == ST_SAMP) && !push) |=> (samp_count == $past(samp_count)))
		else $error("start during sampling disturbed the run");

	a_arm_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(accept_start && start_en) |=> (status == STAT_WAIT) ##1 (state_q != ST_SAMP || $past(take)))
		else $error("enabled start did not hold in trigger wait");

	a_direct_samp: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(accept_start && !start_en) |=> (status == STAT_SAMPLING) && (samp_count == '0))
		else $error("disabled start condition did not sample at once");

	a_fire_samp: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((state_q == ST_WAIT) && take && start_fire && !end_cmd) |=> (state_q == ST_SAMP) && (samp_count == CNT_W'(1)))
		else $error("start firing did not begin capture");

	a_end_fire: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((state_q == ST_SAMP) && take && end_en && end_fire) |=> (status == STAT_WRITING))
		else $error("end condition did not end capture");

	a_buf_full: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((state_q == ST_SAMP) && push && (samp_count == CNT_W'(BUF_SAMPLES - 16'h1))) |=> (state_q == ST_FLUSH))
		else $error("full buffer did not end capture");

	a_manual_end: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((state_q == ST_SAMP) && end_cmd) |=> (state_q == ST_FLUSH) && !samp_ready)
		else $error("manual end did not end capture");

	a_close_drained: assert property (@(posedge clk_sys) disable iff (!reset_n)
		card_close |-> !card_valid && (state_q == ST_CLOSE))
		else $error("card closed before samples drained");

	a_hold_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((state_q == ST_CLOSE) && !card_closed) |=> (status == STAT_WRITING))
		else $error("stop reported before card write done");

	a_power_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(por_go && card_s2_q && (state_q == ST_STOP)) |=> (state_q != ST_STOP))
		else $error("power-on start did not begin sequence");

	a_eval_once: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((state_q == ST_SAMP) && !take && !end_cmd) |=> $stable(samp_count) && (state_q == ST_SAMP))
		else $error("condition acted without a sample");

	a_err_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(storage_err && err_clr && !refuse_start) |=> !storage_err)
		else $error("storage error did not clear");

	a_wait_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((state_q == ST_WAIT) && !(take && start_fire)) |=> $stable(samp_count) && (status != STAT_SAMPLING))
		else $error("capture began before start condition fired");

	a_stop_drained: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(status == STAT_STOP) |-> fifo_idle && !card_valid && !samp_ready)
		else $error("stop shown while samples still pending");

	a_close_once: assert property (@(posedge clk_sys) disable iff (!reset_n)
		card_close |=> !card_close)
		else $error("card close held longer than one cycle");
endmodule

// *** stc_trigger_ctrl_tb.sv ***
// Purpose: Self-checking bench for the sampling trigger controller.
// Assumes: Inputs change at falling edges; the buffer holds four samples here.
// Notes: Each scenario task drives the block and judges the result itself.
`timescale 1ns/1ns
module stc_trigger_ctrl_tb;
	import stc_pkg::*;
	logic clk_sys = 1'b0, reset_n = 1'b0, start_cmd = 1'b0, end_cmd = 1'b0, err_clr = 1'b0;
	logic power_on_start = 1'b0, samp_valid = 1'b0, card_present = 1'b1, slow = 1'b0;
	logic [1:0] start_sel = SEL_OFF, end_sel = SEL_OFF;
	logic [OFF_W-1:0] start_offset = 3'h0, end_offset = 3'h0;
	logic [SIZE_W-1:0] start_size = 3'h1, end_size = 3'h1;
	logic [DATA_W-1:0] start_mask = 32'h0, start_value = 32'h0, end_mask = 32'h0, end_value = 32'h0;
	logic [63:0] samp_rec = 64'h0, card_data, sum, sum_base;
	logic samp_ready, card_valid, card_ready, card_close, card_closed, storage_err, done;
	logic [1:0] status;
	logic [15:0] samp_count;
	int words, base, fail_count = 0, checked = 0;
	localparam logic [2:0] CMD_START = 3'h4, CMD_END = 3'h2, CMD_CLR = 3'h1;
	stc_trigger_ctrl #(.BUF_SAMPLES(16'h0004)) u_stc_trigger_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
		.start_cmd(start_cmd), .end_cmd(end_cmd), .err_clr(err_clr), .power_on_start(power_on_start),
		.start_sel(start_sel), .start_offset(start_offset), .start_size(start_size), .start_mask(start_mask),
		.start_value(start_value), .end_sel(end_sel), .end_offset(end_offset), .end_size(end_size),
		.end_mask(end_mask), .end_value(end_value), .samp_valid(samp_valid), .samp_ready(samp_ready),
		.samp_rec(samp_rec), .card_present(card_present), .card_valid(card_valid), .card_ready(card_ready),
		.card_data(card_data), .card_close(card_close), .card_closed(card_closed), .status(status),
		.storage_err(storage_err), .samp_count(samp_count));
	stc_card_model u_stc_card_model (.clk_sys(clk_sys), .reset_n(reset_n), .card_valid(card_valid),
		.card_ready(card_ready), .card_data(card_data), .card_close(card_close), .card_closed(card_closed),
		.slow(slow), .words(words), .sum(sum), .done(done));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("Mismatches %0d, comparisons %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// One-cycle pulse on the command inputs; returns after the edge that took it.
	task automatic pulse(input logic [2:0] cmd);
		{start_cmd, end_cmd, err_clr} = cmd;
		cyc(1);
		{start_cmd, end_cmd, err_clr} = 3'h0;
	endtask
	task automatic wait_status(input logic [1:0] s);
		int i;
		for (i = 0; i < 300 && status !== s; i++) begin
			cyc(1);
		end
		if (i == 300) begin
			fail_count++;
			end_of_test();
		end
	endtask
	// Offers one record and holds it until the edge where samp_ready is high.
	task automatic send(input logic [63:0] r);
		int i;
		samp_rec = r;
		samp_valid = 1'b1;
		for (i = 0; i < 300 && samp_ready !== 1'b1; i++) begin
			cyc(1);
		end
		if (i == 300) begin
			fail_count++;
			end_of_test();
		end
		cyc(1);
		samp_valid = 1'b0;
		samp_rec = ~r;
		cyc(1);
	endtask
	task automatic finish_run(input int n, input logic [63:0] s);
		wait_status(STAT_STOP);
		chk(done, 1'b1);
		chk(words - base, n);
		chk(sum - sum_base, s);
	endtask
	task automatic s_immediate();
		base = words;
		sum_base = sum;
		slow = 1'b1;
		start_sel = SEL_OFF;
		pulse(CMD_START);
		chk(status, STAT_SAMPLING);
		cyc(1);
		pulse(CMD_START);
		chk(status, STAT_SAMPLING);
		send(64'h1);
		send(64'h2);
		send(64'h3);
		chk(samp_count, 16'h0003);
		pulse(CMD_END);
		chk(status, STAT_WRITING);
		finish_run(3, 64'h6);
		slow = 1'b0;
	endtask
	task automatic s_trigger();
		base = words;
		sum_base = sum;
		start_sel = SEL_MATCH;
		start_mask = 32'h10;
		start_value = 32'h0;
		end_sel = SEL_FIRE_ON_MISMATCH;
		end_offset = 3'h1;
		end_mask = 32'hff;
		end_value = 32'h5a;
		pulse(CMD_START);
		chk(status, STAT_WAIT);
		cyc(1);
		pulse(CMD_START);
		chk(status, STAT_WAIT);
		send(64'h10);
		chk(status, STAT_WAIT);
		send(64'h5aef);
		chk(status, STAT_SAMPLING);
		send(64'h5a10);
		chk(status, STAT_SAMPLING);
		send(64'h0011);
		chk(status, STAT_WRITING);
		chk(samp_count, 16'h0003);
		finish_run(3, 64'hb510);
		start_sel = SEL_OFF;
		end_sel = SEL_OFF;
	endtask
	task automatic s_full();
		base = words;
		sum_base = sum;
		slow = 1'b1;
		start_sel = SEL_FIRE_ON_MISMATCH;
		start_mask = 32'hff;
		start_value = 32'h0;
		end_sel = SEL_MATCH;
		end_offset = 3'h0;
		end_mask = 32'hff;
		end_value = 32'he;
		pulse(CMD_START);
		chk(status, STAT_WAIT);
		send(64'h0);
		chk(status, STAT_WAIT);
		send(64'ha);
		send(64'hb);
		send(64'hc);
		chk(status, STAT_SAMPLING);
		send(64'hd);
		chk(status, STAT_WRITING);
		finish_run(4, 64'h2e);
		start_sel = SEL_OFF;
		end_sel = SEL_OFF;
		slow = 1'b0;
	endtask
	task automatic s_no_card();
		card_present = 1'b0;
		cyc(3);
		pulse(CMD_START);
		cyc(1);
		chk(storage_err, 1'b1);
		chk(status, STAT_STOP);
		chk(samp_ready, 1'b0);
		pulse(CMD_CLR);
		cyc(1);
		chk(storage_err, 1'b0);
		card_present = 1'b1;
		cyc(3);
	endtask
	task automatic s_power_on();
		power_on_start = 1'b1;
		reset_n = 1'b0;
		cyc(3);
		reset_n = 1'b1;
		chk(status, STAT_STOP);
		cyc(4);
		chk(status, STAT_SAMPLING);
		base = words;
		sum_base = sum;
		pulse(CMD_END);
		finish_run(0, 64'h0);
		power_on_start = 1'b0;
	endtask
	initial begin
		cyc(3);
		reset_n = 1'b1;
		cyc(3);
		s_immediate();
		s_trigger();
		s_full();
		s_no_card();
		s_power_on();
		end_of_test();
	end
endmodule
